// ---- src/rsc_reset_ctrl.sv ----
// reset source combiner with apb control and status registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
// Operation
// - level-0 below threshold asserts internal reset when level-0 monitor reset enabled.
// - after level-0 recovers, count 32 oscillator cycles, then release internal reset.
// - every reset selects the low-speed oscillator divided by 8 as cpu clock.
// - level-0 enable comes from option bit 5, 0 enables, taken at hardware reset.
// - software cannot change the option bits; only a flash programmer writes them.
// - no reset clears ram; a write in progress leaves ram undefined.
// - level-1 below threshold resets pins, cpu and registers, then runs from vector.
// - level-1 reset keeps a defined subset of register bits unchanged.
// - variant without level-0: count 32 cycles after level-1 recovers before release.
// - in that variant level-1 enable comes from option bit 6, hardware reset only.
// - level-2 below threshold resets pins, cpu and registers, then runs from vector.
// - level-2 reset preserves a defined subset of registers.
// - watchdog underflow with reset select set resets the device.
// - watchdog reset preserves a subset; ram treated as undefined afterwards.
// - writing 1 to the software reset bit resets the device.
// - software reset preserves a subset and leaves ram untouched.
// - reset pin low holds reset; rising edge restarts from reset vector.
// - after power-on reset the level-0 monitor reset is enabled when option bit 5 is 0.
module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter bit HAS_LVL0 = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset sources
   input wire logic reset_pin_n,
   input wire rsc_det_t det_below,
   input wire logic wdt_underflow,
   // option byte as read from flash
   input wire logic [7:0] option_function_byte,
   // ram write in progress, same clock
   input wire logic ram_write_busy,
   // to the rest of the chip
   output logic sys_reset_n,
   output logic hw_reset,
   output rsc_clk_sel_t cpu_clk_sel,
   output rsc_cause_t last_cause,
   output logic ram_suspect
);

   // ==========================================================
   // input synchronisers
   logic pin_meta;
   logic pin_sync;
   rsc_det_t det_meta;
   rsc_det_t det_sync;

   // power-up values read as pin low and supply below, so reset holds
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         det_meta <= '1;
         det_sync <= '1;
      end else begin
         pin_meta <= reset_pin_n;
         pin_sync <= pin_meta;
         det_meta <= det_below;
         det_sync <= det_meta;
      end
   end

   // ==========================================================
   // control state
   logic [7:0] option_q;
   logic software_reset_req;
   logic watchdog_reset_select;
   logic lvl0_reset_enable;
   logic lvl0_mode_select;
   logic lvl1_reset_enable;
   logic lvl1_mode_select;
   logic lvl0_circuit_enable;
   logic lvl1_circuit_enable;
   logic lvl2_reset_enable;
   rsc_clk_sel_t clk_sel_q;

   logic [NUM_SRC-1:0] src_req;
   logic [NUM_SRC-1:0] src_busy;
   logic int_reset;
   logic int_reset_q;
   logic hw_busy;
   logic lvl0_enabled;
   logic lvl1_enabled;

   // ==========================================================
   // apb decode
   logic wr_en;
   logic setup_rd;
   logic addr_ok;

   assign wr_en = psel & penable & pwrite & ~int_reset;
   assign setup_rd = psel & ~penable;

   always_comb begin
      unique case (paddr)
         ADDR_PROC_MODE_A, ADDR_PROC_MODE_B, ADDR_LVL0_CTRL, ADDR_LVL1_CTRL,
         ADDR_DET_CTRL, ADDR_OPTION, ADDR_CAUSE, ADDR_STATUS,
         ADDR_CLK_CTRL: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // reset sources
   assign lvl0_enabled = HAS_LVL0 & lvl0_reset_enable & lvl0_mode_select
                         & lvl0_circuit_enable;
   assign lvl1_enabled = lvl1_reset_enable & lvl1_mode_select & lvl1_circuit_enable;

   always_comb begin
      src_req = '0;
      src_req[SRC_PIN] = ~pin_sync;
      src_req[SRC_LVL0] = lvl0_enabled & det_sync.lvl0_below;
      src_req[SRC_LVL1] = lvl1_enabled & det_sync.lvl1_below;
      src_req[SRC_LVL2] = lvl2_reset_enable & det_sync.lvl2_below;
      src_req[SRC_WDT] = watchdog_reset_select & wdt_underflow;
      src_req[SRC_SW] = software_reset_req;
   end

   // every source gets the same 32-cycle release after it lets go
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         rsc_release_timer #(
            .COUNT(LOCO_RELEASE_COUNT)
         ) u_timer (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .hold(src_req[g]),
            .busy(src_busy[g])
         );
      end
   endgenerate

   assign int_reset = |src_busy;

   // hardware reset covers the pin and the power-on monitor of this variant
   assign hw_busy = src_busy[SRC_PIN] | (HAS_LVL0 ? src_busy[SRC_LVL0]
                                                  : src_busy[SRC_LVL1]);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_reset_q <= 1'b1;
         sys_reset_n <= 1'b0;
         hw_reset <= 1'b1;
      end else begin
         int_reset_q <= int_reset;
         sys_reset_n <= ~int_reset;
         hw_reset <= hw_busy;
      end
   end

   // ==========================================================
   // option byte: latched only during hardware reset, no bus path
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         option_q <= OPTION_ERASED;
      end else if (hw_busy) begin
         option_q <= option_function_byte;
      end
   end

   // ==========================================================
   // monitor control; these survive resets other than hardware reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lvl0_reset_enable <= 1'b0;
         lvl0_mode_select <= 1'b0;
         lvl0_circuit_enable <= 1'b0;
         lvl1_reset_enable <= 1'b0;
         lvl1_mode_select <= 1'b0;
         lvl1_circuit_enable <= 1'b0;
         lvl2_reset_enable <= 1'b0;
      end else if (hw_busy) begin
         // option monitor bit (5, or 6 in the variant) at 0 starts the monitor with all three bits set
         lvl0_reset_enable <= HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL0_MONITOR];
         lvl0_mode_select <= HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL0_MONITOR];
         lvl0_circuit_enable <= HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL0_MONITOR];
         lvl1_reset_enable <= ~HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL1_MONITOR];
         lvl1_mode_select <= ~HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL1_MONITOR];
         lvl1_circuit_enable <= ~HAS_LVL0 & ~option_function_byte[BIT_OPT_LVL1_MONITOR];
         lvl2_reset_enable <= 1'b0;
      end else if (wr_en) begin
         // other resets leave these alone, the preserved subset
         unique case (paddr)
            ADDR_LVL0_CTRL: begin
               lvl0_reset_enable <= pwdata[BIT_LVL_RESET_ENABLE];
               lvl0_mode_select <= pwdata[BIT_LVL_MODE_SELECT];
            end
            ADDR_LVL1_CTRL: begin
               lvl1_reset_enable <= pwdata[BIT_LVL_RESET_ENABLE];
               lvl1_mode_select <= pwdata[BIT_LVL_MODE_SELECT];
            end
            ADDR_DET_CTRL: begin
               lvl0_circuit_enable <= pwdata[BIT_LVL0_CIRCUIT_ENABLE];
               lvl1_circuit_enable <= pwdata[BIT_LVL1_CIRCUIT_ENABLE];
               lvl2_reset_enable <= pwdata[BIT_LVL2_RESET_ENABLE];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // processor mode bits; cleared by every internal reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         software_reset_req <= 1'b0;
         watchdog_reset_select <= 1'b0;
      end else if (int_reset) begin
         software_reset_req <= 1'b0;
         watchdog_reset_select <= 1'b0;
      end else begin
         // the reset bit is a one-shot and never reads back as 1
         software_reset_req <= wr_en && paddr == ADDR_PROC_MODE_A
                               && pwdata[BIT_SOFTWARE_RESET];
         if (wr_en && paddr == ADDR_PROC_MODE_B) begin
            watchdog_reset_select <= pwdata[BIT_WATCHDOG_RESET_SELECT];
         end
      end
   end

   // ==========================================================
   // cpu clock select
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         clk_sel_q <= CLK_LOCO_DIV8;
      end else if (int_reset) begin
         clk_sel_q <= CLK_LOCO_DIV8;
      end else if (wr_en && paddr == ADDR_CLK_CTRL) begin
         clk_sel_q <= rsc_clk_sel_t'(pwdata[1:0]);
      end
   end

   assign cpu_clk_sel = clk_sel_q;

   // ==========================================================
   // cause of last reset: restarted on entry, gathers sources while held
   rsc_cause_t cause_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cause_q <= '0;
      end else if (int_reset && !int_reset_q) begin
         cause_q <= rsc_cause_t'(src_req);
      end else if (int_reset) begin
         cause_q <= rsc_cause_t'(NUM_SRC'(cause_q) | src_req);
      end
   end

   assign last_cause = cause_q;

   // ==========================================================
   // ram integrity flag; ram itself is never cleared here
   logic ram_suspect_q;
   logic ram_hit;
   logic ram_clr;

   assign ram_hit = (int_reset & ~int_reset_q & ram_write_busy)
                    | src_req[SRC_WDT];
   assign ram_clr = wr_en && paddr == ADDR_STATUS && pwdata[BIT_STAT_RAM_SUSPECT];

   // a new hit wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ram_suspect_q <= 1'b0;
      end else if (ram_hit) begin
         ram_suspect_q <= 1'b1;
      end else if (ram_clr) begin
         ram_suspect_q <= 1'b0;
      end
   end

   assign ram_suspect = ram_suspect_q;

   // ==========================================================
   // apb read data, captured in the setup cycle
   logic [31:0] next_rdata;
   logic err_q;

   always_comb begin
      next_rdata = DATA_ZERO;
      unique case (paddr)
         ADDR_PROC_MODE_B: next_rdata[BIT_WATCHDOG_RESET_SELECT] = watchdog_reset_select;
         ADDR_LVL0_CTRL: begin
            next_rdata[BIT_LVL_RESET_ENABLE] = lvl0_reset_enable;
            next_rdata[BIT_LVL_MODE_SELECT] = lvl0_mode_select;
         end
         ADDR_LVL1_CTRL: begin
            next_rdata[BIT_LVL_RESET_ENABLE] = lvl1_reset_enable;
            next_rdata[BIT_LVL_MODE_SELECT] = lvl1_mode_select;
         end
         ADDR_DET_CTRL: begin
            next_rdata[BIT_LVL0_CIRCUIT_ENABLE] = lvl0_circuit_enable;
            next_rdata[BIT_LVL1_CIRCUIT_ENABLE] = lvl1_circuit_enable;
            next_rdata[BIT_LVL2_RESET_ENABLE] = lvl2_reset_enable;
         end
         ADDR_OPTION: next_rdata[7:0] = option_q;
         ADDR_CAUSE: next_rdata[NUM_SRC-1:0] = cause_q;
         ADDR_STATUS: begin
            next_rdata[2:0] = det_sync;
            next_rdata[3] = ~pin_sync;
            next_rdata[BIT_STAT_RAM_SUSPECT] = ram_suspect_q;
         end
         ADDR_CLK_CTRL: next_rdata[1:0] = clk_sel_q;
         default: next_rdata = DATA_ZERO;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata <= DATA_ZERO;
         err_q <= 1'b0;
      end else if (setup_rd) begin
         prdata <= pwrite ? DATA_ZERO : next_rdata;
         err_q <= ~addr_ok;
      end
   end

   // zero wait states: the access phase always completes at its first edge
   assign pready = psel & penable;
   assign pslverr = psel & penable & err_q;

endmodule

// ---- src/rsc_pkg.sv ----
// shared constants, types and register map of the reset source controller
package rsc_pkg;

   // ==========================================================
   // register map (byte addresses on the apb slave)
   localparam logic [7:0] ADDR_PROC_MODE_A = 8'h00;
   localparam logic [7:0] ADDR_PROC_MODE_B = 8'h04;
   localparam logic [7:0] ADDR_LVL0_CTRL = 8'h08;
   localparam logic [7:0] ADDR_LVL1_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_DET_CTRL = 8'h10;
   localparam logic [7:0] ADDR_OPTION = 8'h14;
   localparam logic [7:0] ADDR_CAUSE = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_CLK_CTRL = 8'h20;

   // ==========================================================
   // field positions
   localparam int BIT_SOFTWARE_RESET = 3;
   localparam int BIT_WATCHDOG_RESET_SELECT = 2;
   localparam int BIT_LVL_RESET_ENABLE = 0;
   localparam int BIT_LVL_MODE_SELECT = 6;
   localparam int BIT_LVL0_CIRCUIT_ENABLE = 5;
   localparam int BIT_LVL1_CIRCUIT_ENABLE = 6;
   localparam int BIT_LVL2_RESET_ENABLE = 7;
   localparam int BIT_OPT_LVL0_MONITOR = 5;
   localparam int BIT_OPT_LVL1_MONITOR = 6;
   localparam int BIT_STAT_RAM_SUSPECT = 4;

   // ==========================================================
   // values after reset and counts
   localparam logic [7:0] OPTION_ERASED = 8'hff;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   localparam int LOCO_RELEASE_COUNT = 32;
   localparam int RELEASE_CNT_W = 6;

   // ==========================================================
   // reset sources, one index each
   localparam int NUM_SRC = 6;
   localparam int SRC_PIN = 0;
   localparam int SRC_LVL0 = 1;
   localparam int SRC_LVL1 = 2;
   localparam int SRC_LVL2 = 3;
   localparam int SRC_WDT = 4;
   localparam int SRC_SW = 5;

   typedef struct packed {
      logic software;
      logic watchdog;
      logic lvl2;
      logic lvl1;
      logic lvl0;
      logic pin;
   } rsc_cause_t;

   // comparator flags, high while supply is at or below the threshold
   typedef struct packed {
      logic lvl2_below;
      logic lvl1_below;
      logic lvl0_below;
   } rsc_det_t;

   typedef enum logic [1:0] {
      CLK_LOCO_DIV8,
      CLK_LOCO,
      CLK_MAIN_DIV8,
      CLK_MAIN
   } rsc_clk_sel_t;

endpackage

// ---- src/rsc_release_timer.sv ----
// hold-and-release counter for one reset source
`timescale 1ns/1ps
module rsc_release_timer
   import rsc_pkg::*;
#(
   parameter int COUNT = LOCO_RELEASE_COUNT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // source
   input wire logic hold,
   output logic busy
);

   logic [RELEASE_CNT_W-1:0] cnt;
   logic armed;

   // the count restarts whenever the source reasserts
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         armed <= 1'b1;
      end else if (hold) begin
         cnt <= '0;
         armed <= 1'b1;
      end else if (armed) begin
         if (cnt == RELEASE_CNT_W'(COUNT - 1)) begin
            armed <= 1'b0;
         end
         cnt <= cnt + 1'b1;
      end
   end

   assign busy = hold | armed;

endmodule

// ---- test/rsc_reset_ctrl_assertions.sv ----
// concurrent checks on the ports of the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_assertions
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // sources and results
   input wire logic reset_pin_n,
   input wire logic ram_write_busy,
   input wire logic sys_reset_n,
   input wire logic hw_reset,
   input wire rsc_clk_sel_t cpu_clk_sel,
   input wire rsc_cause_t last_cause,
   input wire logic ram_suspect
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // ==========================================================
   // helper: edges seen with the internal reset low, saturating
   logic [7:0] low_cnt;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         low_cnt <= 8'h00;
      end else if (sys_reset_n) begin
         low_cnt <= 8'h00;
      end else if (low_cnt != 8'hff) begin
         low_cnt <= low_cnt + 8'h01;
      end
   end

   // ==========================================================
   // assertions
   chk_release_count: assert property (
      $rose(sys_reset_n) |-> low_cnt >= 8'h20) else $error("release before count");
   chk_clk_default: assert property (
      $rose(sys_reset_n) |-> cpu_clk_sel == CLK_LOCO_DIV8) else $error("clock not slow");
   chk_pin_hold: assert property (
      !reset_pin_n [*4] |-> !sys_reset_n && hw_reset) else $error("pin low not held");
   chk_cause_recorded: assert property (
      $fell(sys_reset_n) |=> last_cause != 6'h00) else $error("cause not recorded");
   chk_sw_reset: assert property (
      psel && penable && pwrite && sys_reset_n && paddr == ADDR_PROC_MODE_A
      && pwdata[BIT_SOFTWARE_RESET] |-> ##[1:3] !sys_reset_n) else $error("no sw reset");
   chk_ram_write: assert property (
      $fell(sys_reset_n) && ram_write_busy && $past(ram_write_busy)
      |-> ##[0:1] ram_suspect) else $error("ram hazard not flagged");
   chk_wdt_ram: assert property (
      $rose(last_cause.watchdog) |-> ##[0:1] ram_suspect) else $error("wdt ram not flagged");
   chk_hw_holds: assert property (
      hw_reset |-> !sys_reset_n) else $error("hw reset without internal reset");
   chk_apb_answer: assert property (
      psel && penable |-> pready && (pslverr == (paddr > ADDR_CLK_CTRL)))
      else $error("apb answer wrong");

   cover property ($rose(sys_reset_n) && last_cause.software);
   cover property ($rose(sys_reset_n) && last_cause.lvl0);
   cover property ($rose(sys_reset_n) && last_cause.watchdog);
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the reset source controller
`timescale 1ns/1ps
module tb_top
   import rsc_pkg::*;
();
   // 2 sync edges, the release count, then the registered output
   localparam int REL = 3 + LOCO_RELEASE_COUNT;
   logic clk_sys = 1'b0;
   logic rstn, psel, penable, pwrite, pready, pslverr, err;
   logic reset_pin_n, wdt_underflow, ram_write_busy, sys_reset_n, hw_reset, ram_suspect;
   logic lvl1_sys_reset_n;
   logic [7:0] paddr, option_function_byte;
   logic [31:0] pwdata, prdata, rdat;
   rsc_det_t det_below;
   rsc_clk_sel_t cpu_clk_sel;
   rsc_cause_t last_cause;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   always #50 clk_sys = ~clk_sys;

   rsc_reset_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_n(reset_pin_n), .det_below(det_below),
      .wdt_underflow(wdt_underflow), .option_function_byte(option_function_byte),
      .ram_write_busy(ram_write_busy), .sys_reset_n(sys_reset_n), .hw_reset(hw_reset),
      .cpu_clk_sel(cpu_clk_sel), .last_cause(last_cause), .ram_suspect(ram_suspect));

   // variant without the level-0 monitor; shares every input, only its reset is judged
   rsc_reset_ctrl #(.HAS_LVL0(1'b0)) dut_lvl1 (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
      .pready(), .pslverr(), .reset_pin_n(reset_pin_n), .det_below(det_below),
      .wdt_underflow(wdt_underflow), .option_function_byte(option_function_byte),
      .ram_write_busy(ram_write_busy), .sys_reset_n(lvl1_sys_reset_n), .hw_reset(),
      .cpu_clk_sel(), .last_cause(), .ram_suspect());

   // ==========================================================
   // reporting and compare
   task give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task cmpn(input int got, input int exp, input string what);
      samples_checked++;
      if (got != exp) begin
         n_fail++;
         $display("Error t=%0t %s took %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // ==========================================================
   // apb master and waits
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      cmp(pready, 1'b1, "pready");
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rdat, exp, what);
   endtask

   task wait_rst(input logic v, output int m);
      m = 0;
      do begin
         @(posedge clk_sys);
         #1;
         m++;
      end while (sys_reset_n !== v && m < 400);
   endtask

   task wait_var(input logic v, output int m);
      m = 0;
      do begin
         @(posedge clk_sys);
         #1;
         m++;
      end while (lvl1_sys_reset_n !== v && m < 400);
   endtask

   // ==========================================================
   // scenarios
   task t_power_on();
      @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      wait_rst(1'b1, n);
      cmpn(n, REL, "power-on release");
      cmp(last_cause.pin, 1'b1, "cause pin");
      cmp(cpu_clk_sel, CLK_LOCO_DIV8, "clock");
      rd(ADDR_LVL0_CTRL, 32'h41, "lvl0 ctrl");
      rd(ADDR_DET_CTRL, 32'h20, "det ctrl");
      apb(1'b1, ADDR_OPTION, 32'h0000_0000);
      rd(ADDR_OPTION, 32'hdf, "option ro");
      rd(8'h24, 32'h0000_0000, "unmapped");
      cmp(err, 1'b1, "slverr");
      $display("test power_on done");
   endtask

   task t_lvl0();
      apb(1'b1, ADDR_CLK_CTRL, 32'h3);
      rd(ADDR_CLK_CTRL, 32'h3, "clk ctrl");
      cmp(cpu_clk_sel, CLK_MAIN, "clock set");
      @(posedge clk_sys);
      det_below.lvl0_below <= 1'b1;
      wait_rst(1'b0, n);
      cmpn(n, 3, "lvl0 entry");
      cmp(hw_reset, 1'b1, "hw reset");
      repeat (5) @(posedge clk_sys);
      det_below.lvl0_below <= 1'b0;
      wait_rst(1'b1, n);
      cmpn(n, REL, "lvl0 release");
      cmp(last_cause, 6'h02, "cause lvl0");
      cmp(cpu_clk_sel, CLK_LOCO_DIV8, "clock back");
      rd(ADDR_CLK_CTRL, 32'h0, "clk ctrl reset");
      $display("test lvl0 done");
   endtask

   task t_option();
      @(posedge clk_sys);
      option_function_byte <= 8'hff;
      apb(1'b1, ADDR_PROC_MODE_A, 32'h08);
      wait_rst(1'b0, n);
      wait_rst(1'b1, n);
      cmp(last_cause, 6'h20, "cause sw");
      rd(ADDR_LVL0_CTRL, 32'h41, "kept by sw reset");
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      wait_rst(1'b0, n);
      cmpn(n, 3, "pin entry");
      repeat (5) @(posedge clk_sys);
      cmp(hw_reset, 1'b1, "pin hw reset");
      reset_pin_n <= 1'b1;
      wait_rst(1'b1, n);
      cmpn(n, REL, "pin release");
      rd(ADDR_OPTION, 32'hff, "option taken");
      apb(1'b0, ADDR_LVL0_CTRL, 32'h0);
      cmp(rdat[BIT_LVL_RESET_ENABLE], 1'b0, "lvl0 disabled");
      @(posedge clk_sys);
      det_below.lvl0_below <= 1'b1;
      repeat (40) @(posedge clk_sys);
      cmp(sys_reset_n, 1'b1, "disabled lvl0 ignored");
      det_below.lvl0_below <= 1'b0;
      option_function_byte <= 8'h9f;
      reset_pin_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      wait_rst(1'b1, n);
      rd(ADDR_LVL0_CTRL, 32'h41, "lvl0 re-enabled");
      $display("test option done");
   endtask

   task t_variant();
      @(posedge clk_sys);
      det_below.lvl1_below <= 1'b1;
      wait_var(1'b0, n);
      cmpn(n, 3, "lvl1 entry");
      cmp(sys_reset_n, 1'b1, "lvl1 off in main");
      @(posedge clk_sys);
      det_below.lvl1_below <= 1'b0;
      wait_var(1'b1, n);
      cmpn(n, REL, "lvl1 release");
      $display("test variant done");
   endtask

   task t_lvl2();
      apb(1'b1, ADDR_DET_CTRL, 32'ha0);
      @(posedge clk_sys);
      det_below.lvl2_below <= 1'b1;
      wait_rst(1'b0, n);
      cmpn(n, 3, "lvl2 entry");
      cmp(hw_reset, 1'b0, "lvl2 not hw");
      repeat (3) @(posedge clk_sys);
      det_below.lvl2_below <= 1'b0;
      wait_rst(1'b1, n);
      cmpn(n, REL, "lvl2 release");
      cmp(last_cause, 6'h08, "cause lvl2");
      rd(ADDR_DET_CTRL, 32'ha0, "det kept");
      $display("test lvl2 done");
   endtask

   task t_wdt();
      @(posedge clk_sys);
      wdt_underflow <= 1'b1;
      @(posedge clk_sys);
      wdt_underflow <= 1'b0;
      repeat (10) @(posedge clk_sys);
      cmp(sys_reset_n, 1'b1, "wdt unselected");
      apb(1'b1, ADDR_PROC_MODE_B, 32'h04);
      rd(ADDR_PROC_MODE_B, 32'h04, "wdt select");
      @(posedge clk_sys);
      wdt_underflow <= 1'b1;
      @(posedge clk_sys);
      wdt_underflow <= 1'b0;
      // counted from the edge after the pulse was dropped
      wait_rst(1'b0, n);
      cmpn(n, 1, "wdt entry");
      wait_rst(1'b1, n);
      cmp(last_cause, 6'h10, "cause wdt");
      cmp(ram_suspect, 1'b1, "wdt ram");
      rd(ADDR_PROC_MODE_B, 32'h0, "select cleared");
      rd(ADDR_LVL0_CTRL, 32'h41, "kept by wdt");
      $display("test wdt done");
   endtask

   task t_sw();
      apb(1'b1, ADDR_STATUS, 32'h10);
      @(posedge clk_sys);
      cmp(ram_suspect, 1'b0, "flag cleared");
      ram_write_busy <= 1'b1;
      apb(1'b1, ADDR_PROC_MODE_A, 32'h08);
      wait_rst(1'b0, n);
      @(posedge clk_sys);
      ram_write_busy <= 1'b0;
      wait_rst(1'b1, n);
      cmp(ram_suspect, 1'b1, "ram write hit");
      cmp(last_cause, 6'h20, "cause sw");
      rd(ADDR_PROC_MODE_A, 32'h0, "sw bit reads 0");
      apb(1'b1, ADDR_STATUS, 32'h10);
      apb(1'b1, ADDR_PROC_MODE_A, 32'h08);
      wait_rst(1'b0, n);
      wait_rst(1'b1, n);
      cmp(ram_suspect, 1'b0, "ram untouched");
      rd(ADDR_DET_CTRL, 32'ha0, "kept by sw");
      $display("test sw done");
   endtask

   // ==========================================================
   // watchdog on the run and main sequence
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("Error t=%0t timeout", $time);
         give_verdict();
      end
   end

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      reset_pin_n = 1'b0;
      det_below = 3'h0;
      wdt_underflow = 1'b0;
      ram_write_busy = 1'b0;
      option_function_byte = 8'hdf;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      t_power_on();
      t_lvl0();
      t_option();
      t_variant();
      t_lvl2();
      t_wdt();
      t_sw();
      give_verdict();
   end
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
   .ram_write_busy(ram_write_busy), .sys_reset_n(sys_reset_n), .hw_reset(hw_reset),
   .cpu_clk_sel(cpu_clk_sel), .last_cause(last_cause), .ram_suspect(ram_suspect));
